// ==== include/ssc_map.svh ====
// constants of the supply and debug control block: reset values and timing counts
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

// clock period, in ns
`define SSC_CLK_PERIOD_NS 10
// settle time for the reset pin after a drive change, a least time
`define SSC_RST_SETTLE_NS 2000
`define SSC_RST_SETTLE_CYC ((`SSC_RST_SETTLE_NS + `SSC_CLK_PERIOD_NS - 1) / `SSC_CLK_PERIOD_NS)
// width of the settle counter
`define SSC_RST_CNT_W 9

// reset values, and the safe mode used during debug
`define SSC_RST_IO_MODE 2'h0
`define SSC_RST_MUX_SEL 3'h0
`define SSC_RST_SAFE_MODE 2'h0
`define SSC_DEBUG_SAFE_MODE 2'h0

// low-power overcurrent action codes
`define SSC_OC_ACT_WAKE 2'h0
`define SSC_OC_ACT_TIMER 2'h1
`define SSC_OC_ACT_REFRESH 2'h2

// positions in the synchronised input vector
`define SSC_SY_OVERCUR 0
`define SSC_SY_AUX_UV 1
`define SSC_SY_AUX_OC 2
`define SSC_SY_RST_PIN 3
`define SSC_SY_BELOW_UP 4
`define SSC_SY_BELOW_LO 5
`define SSC_SY_DEBUG_WIN 6
`define SSC_SY_RES_LO 7
`define SSC_SY_IO_LO 9
`define SSC_SY_CYC 13
`define SSC_SY_W 14

`endif

// ==== include/ssc_pkg.sv ====
// types of the supply and debug control block
package ssc_pkg;

  // general i/o pin configuration
  typedef enum logic [1:0] {
    SSC_IO_INPUT = 2'h0,
    SSC_IO_HIGH_SIDE = 2'h1,
    SSC_IO_LOW_SIDE = 2'h2,
    SSC_IO_HIZ = 2'h3
  } ssc_io_mode_e;

  // analog monitor sources
  typedef enum logic [2:0] {
    SSC_MON_MAIN_SUPPLY = 3'h0,
    SSC_MON_BATTERY_SENSE = 3'h1,
    SSC_MON_IO0 = 3'h2,
    SSC_MON_IO1 = 3'h3,
    SSC_MON_REF_2V5 = 3'h4,
    SSC_MON_DIE_TEMP = 3'h5,
    SSC_MON_CUR_COPY = 3'h6
  } ssc_mon_src_e;

  // debug mode state, one-hot
  typedef enum logic [2:0] {
    SSC_DBG_IDLE = 3'h1,
    SSC_DBG_ACTIVE = 3'h2,
    SSC_DBG_LEFT = 3'h4
  } ssc_debug_e;

  typedef logic [1:0] ssc_safe_mode_t;

endpackage

// ==== design/ssc_sync.sv ====
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module ssc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

// ==== design/ssc_supply_ctrl.sv ====
// supply enables, reset and undervoltage handling, i/o, monitor, debug and fail-safe control
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_supply_ctrl
  import ssc_pkg::*;
#(
  parameter int IO_N = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // device mode, from the mode logic on this clock
  input wire logic init_enter,
  input wire logic mode_normal,
  input wire logic mode_low_power,
  input wire logic mode_low_power_vdd_on,
  input wire logic cyclic_sense_en,
  input wire logic reset_request,
  input wire logic fault_event,
  // software settings, from the serial decoder on this clock
  input wire logic cfg_pnp_en,
  input wire logic [1:0] cfg_overcur_action,
  input wire logic cfg_uv_lower_sel,
  input wire logic cfg_aux_irq_en,
  input wire logic cfg_mon_load_en,
  input wire logic wr_can_reg,
  input wire logic wr_can_reg_on,
  input wire logic wr_aux,
  input wire logic wr_aux_on,
  input wire logic wr_aux_3v3,
  input wire logic wr_aux_flag_clr,
  input wire logic wr_rst_fail_clr,
  input wire logic wr_io,
  input wire logic [2*IO_N-1:0] wr_io_mode,
  input wire logic wr_mon,
  input wire logic [2:0] wr_mon_sel,
  input wire logic wr_debug_exit,
  input wire logic wr_safe,
  input wire logic [1:0] wr_safe_mode,
  input wire logic wr_safe_release,
  // analog detectors and pins, asynchronous
  input wire logic vdd_overcur_in,
  input wire logic aux_uv_in,
  input wire logic aux_oc_in,
  input wire logic rst_pin_in,
  input wire logic uv_threshold_upper,
  input wire logic uv_threshold_lower,
  input wire logic debug_select_pin,
  input wire logic [1:0] debug_res_code,
  input wire logic [IO_N-1:0] io_pin_in,
  input wire logic cyclic_clk_in,
  // supply controls
  output logic pnp_base_en,
  output logic can_reg_en,
  output logic lin_trx_en,
  output logic aux_regulator_en,
  output logic aux_3v3,
  output logic aux_fault_flag,
  output logic aux_irq,
  // low-power overcurrent events
  output logic oc_wake,
  output logic oc_timer_start,
  output logic oc_wdog_refresh,
  // reset pin, open drain, and undervoltage interrupt
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic rst_fail_flag,
  output logic uv_irq,
  // general i/o
  output logic [IO_N-1:0] io_hs_on,
  output logic [IO_N-1:0] io_ls_on,
  output logic [IO_N-1:0] io_wake_in,
  output logic io_prot_en,
  // analog monitor
  output logic analog_monitor_en,
  output logic [2:0] analog_monitor_sel,
  output logic analog_monitor_load,
  // debug and watchdog
  output logic debug_active,
  output logic wdog_enable,
  // fail-safe
  output logic [1:0] safe_mode,
  output logic safe_pin_out,
  output logic safe_pin_oe
);

  // reset release through two flops
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire srst_n = rst_sync_ff;

  // all pin and detector levels cross into the clock domain here
  logic [`SSC_SY_W-1:0] sy;
  ssc_sync #(.W(`SSC_SY_W)) u_sync (
    .clk(clk),
    .rst_n(srst_n),
    .din({cyclic_clk_in, io_pin_in, debug_res_code, debug_select_pin, uv_threshold_lower,
          uv_threshold_upper, rst_pin_in, aux_oc_in, aux_uv_in, vdd_overcur_in}),
    .dout(sy)
  );
  wire s_overcur = sy[`SSC_SY_OVERCUR];
  wire s_aux_fault = sy[`SSC_SY_AUX_UV] | sy[`SSC_SY_AUX_OC];
  wire s_rst_pin = sy[`SSC_SY_RST_PIN];
  wire s_below_up = sy[`SSC_SY_BELOW_UP];
  wire s_below_lo = sy[`SSC_SY_BELOW_LO];
  wire s_debug_win = sy[`SSC_SY_DEBUG_WIN];
  wire [1:0] s_res_code = sy[`SSC_SY_RES_LO +: 2];
  wire [IO_N-1:0] s_io = sy[`SSC_SY_IO_LO +: IO_N];
  wire s_cyc = sy[`SSC_SY_CYC];

  // edge history for the detectors that raise events
  logic overcur_d_ff;
  logic aux_fault_d_ff;
  logic below_up_d_ff;
  logic cyc_d_ff;
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      overcur_d_ff <= 1'b0;
      aux_fault_d_ff <= 1'b0;
      below_up_d_ff <= 1'b0;
      cyc_d_ff <= 1'b0;
    end else begin
      overcur_d_ff <= s_overcur;
      aux_fault_d_ff <= s_aux_fault;
      below_up_d_ff <= s_below_up;
      cyc_d_ff <= s_cyc;
    end
  end

  // low-power overcurrent event and the action picked for it
  wire overcur_evt = mode_low_power_vdd_on & s_overcur & ~overcur_d_ff;
  wire nxt_oc_wake = overcur_evt & (cfg_overcur_action == `SSC_OC_ACT_WAKE);
  wire nxt_oc_timer = overcur_evt & (cfg_overcur_action == `SSC_OC_ACT_TIMER);
  wire nxt_oc_refresh = overcur_evt & (cfg_overcur_action == `SSC_OC_ACT_REFRESH);

  // debug state machine
  ssc_debug_e dbg_ff;
  ssc_debug_e nxt_dbg;
  always_comb begin
    nxt_dbg = dbg_ff;
    case (dbg_ff)
      SSC_DBG_IDLE: begin
        if (init_enter && s_debug_win) begin
          nxt_dbg = SSC_DBG_ACTIVE;
        end
      end
      SSC_DBG_ACTIVE: begin
        // the command wins even while the window voltage stays present
        if (wr_debug_exit || !s_debug_win) begin
          nxt_dbg = SSC_DBG_LEFT;
        end
      end
      SSC_DBG_LEFT: nxt_dbg = SSC_DBG_LEFT;
      default: nxt_dbg = SSC_DBG_IDLE;
    endcase
  end
  wire nxt_debug = (nxt_dbg == SSC_DBG_ACTIVE);
  wire debug_enter = nxt_debug & (dbg_ff == SSC_DBG_IDLE);

  // transceiver supply: off at reset, set by software command, switched on at debug entry
  wire nxt_can_reg = debug_enter ? 1'b1 : (wr_can_reg ? wr_can_reg_on : can_reg_en);

  // monitor selection is dropped while the transceiver supply is off
  wire mon_take = wr_mon & can_reg_en & (wr_mon_sel <= 3'(SSC_MON_CUR_COPY));
  wire [2:0] nxt_mon_sel = mon_take ? wr_mon_sel : analog_monitor_sel;

  // aux regulator: a fault switches it off; set wins over clear on the flag
  wire aux_fault_evt = s_aux_fault & ~aux_fault_d_ff;
  wire nxt_aux_en = s_aux_fault ? 1'b0 : (wr_aux ? wr_aux_on : aux_regulator_en);
  wire nxt_aux_3v3 = wr_aux ? wr_aux_3v3 : aux_3v3;
  wire nxt_aux_flag = aux_fault_evt | (aux_fault_flag & ~wr_aux_flag_clr);
  wire nxt_aux_irq = aux_fault_evt & cfg_aux_irq_en;

  // undervoltage: lower threshold selected in normal mode turns the upper one into an interrupt
  wire uv_irq_mode = cfg_uv_lower_sel & mode_normal;
  wire uv_reset = uv_irq_mode ? s_below_lo : (s_below_up | s_below_lo);
  wire nxt_uv_irq = uv_irq_mode & s_below_up & ~below_up_d_ff;
  wire nxt_rst_drive = uv_reset | reset_request;

  // reset pin check after the pin has had time to follow the drive
  logic [`SSC_RST_CNT_W-1:0] rst_cnt_ff;
  wire rst_settled = (rst_cnt_ff == `SSC_RST_CNT_W'(`SSC_RST_SETTLE_CYC));
  wire drive_change = (nxt_rst_drive != rst_pin_oe);
  wire [`SSC_RST_CNT_W-1:0] nxt_rst_cnt = drive_change ? '0 :
                                          (rst_settled ? rst_cnt_ff : rst_cnt_ff + `SSC_RST_CNT_W'(1));
  wire rst_stuck = rst_settled & (s_rst_pin == rst_pin_oe);
  wire nxt_rst_fail = rst_stuck | (rst_fail_flag & ~wr_rst_fail_clr);

  // cyclic sense window follows the edges of the sampled sense clock
  logic cyc_on_ff;
  wire nxt_cyc_on = (s_cyc & ~cyc_d_ff) ? 1'b1 : ((~s_cyc & cyc_d_ff) ? 1'b0 : cyc_on_ff);

  // i/o configuration registers and drive
  logic [2*IO_N-1:0] io_mode_ff;
  logic [IO_N-1:0] nxt_io_hs;
  logic [IO_N-1:0] nxt_io_ls;
  logic [IO_N-1:0] nxt_io_wake;
  wire [2*IO_N-1:0] nxt_io_mode = wr_io ? wr_io_mode : io_mode_ff;
  genvar gi;
  generate
    for (gi = 0; gi < IO_N; gi++) begin : g_io
      wire [1:0] m = io_mode_ff[2*gi +: 2];
      // pin 0 is the switched output and the rest wake inputs while sensing
      wire sense_out = cyclic_sense_en & (gi == 0);
      wire sense_in = cyclic_sense_en & (gi != 0);
      wire drive_ok = ~sense_in & (~sense_out | cyc_on_ff);
      // configured state holds in low power as well
      assign nxt_io_hs[gi] = drive_ok & (m == 2'(SSC_IO_HIGH_SIDE));
      assign nxt_io_ls[gi] = drive_ok & (m == 2'(SSC_IO_LOW_SIDE));
      assign nxt_io_wake[gi] = (sense_in | (m == 2'(SSC_IO_INPUT))) & s_io[gi];
    end
  endgenerate

  // fail-safe mode and output; set wins over release
  logic safe_override_ff;
  logic [1:0] safe_sw_ff;
  wire [1:0] nxt_safe_sw = wr_safe ? wr_safe_mode : safe_sw_ff;
  wire nxt_safe_override = wr_safe | safe_override_ff;
  wire [1:0] res_mode = nxt_debug ? `SSC_DEBUG_SAFE_MODE : s_res_code;
  wire [1:0] nxt_safe_mode = nxt_safe_override ? nxt_safe_sw : res_mode;
  wire nxt_safe_low = fault_event | (safe_pin_oe & ~wr_safe_release);

  // state and setting registers
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      dbg_ff <= SSC_DBG_IDLE;
      can_reg_en <= 1'b0;
      analog_monitor_sel <= `SSC_RST_MUX_SEL;
      aux_regulator_en <= 1'b0;
      aux_3v3 <= 1'b0;
      aux_fault_flag <= 1'b0;
      io_mode_ff <= {IO_N{`SSC_RST_IO_MODE}};
      cyc_on_ff <= 1'b0;
      rst_cnt_ff <= '0;
      rst_fail_flag <= 1'b0;
      safe_override_ff <= 1'b0;
      safe_sw_ff <= `SSC_RST_SAFE_MODE;
    end else begin
      dbg_ff <= nxt_dbg;
      can_reg_en <= nxt_can_reg;
      analog_monitor_sel <= nxt_mon_sel;
      aux_regulator_en <= nxt_aux_en;
      aux_3v3 <= nxt_aux_3v3;
      aux_fault_flag <= nxt_aux_flag;
      io_mode_ff <= nxt_io_mode;
      cyc_on_ff <= nxt_cyc_on;
      rst_cnt_ff <= nxt_rst_cnt;
      rst_fail_flag <= nxt_rst_fail;
      safe_override_ff <= nxt_safe_override;
      safe_sw_ff <= nxt_safe_sw;
    end
  end

  // registered outputs derived from the settings above
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      pnp_base_en <= 1'b0;
      lin_trx_en <= 1'b0;
      analog_monitor_en <= 1'b0;
      analog_monitor_load <= 1'b0;
      aux_irq <= 1'b0;
      oc_wake <= 1'b0;
      oc_timer_start <= 1'b0;
      oc_wdog_refresh <= 1'b0;
      rst_pin_out <= 1'b0;
      rst_pin_oe <= 1'b1;
      uv_irq <= 1'b0;
      io_hs_on <= '0;
      io_ls_on <= '0;
      io_wake_in <= '0;
      io_prot_en <= 1'b0;
      debug_active <= 1'b0;
      wdog_enable <= 1'b1;
      safe_mode <= `SSC_RST_SAFE_MODE;
      safe_pin_out <= 1'b0;
      safe_pin_oe <= 1'b0;
    end else begin
      pnp_base_en <= cfg_pnp_en;
      lin_trx_en <= nxt_can_reg;
      analog_monitor_en <= nxt_can_reg;
      analog_monitor_load <= cfg_mon_load_en & nxt_can_reg;
      aux_irq <= nxt_aux_irq;
      oc_wake <= nxt_oc_wake;
      oc_timer_start <= nxt_oc_timer;
      oc_wdog_refresh <= nxt_oc_refresh;
      rst_pin_out <= 1'b0;
      rst_pin_oe <= nxt_rst_drive;
      uv_irq <= nxt_uv_irq;
      io_hs_on <= nxt_io_hs;
      io_ls_on <= nxt_io_ls;
      io_wake_in <= nxt_io_wake;
      io_prot_en <= ~mode_low_power;
      debug_active <= nxt_debug;
      wdog_enable <= ~nxt_debug;
      safe_mode <= nxt_safe_mode;
      safe_pin_out <= 1'b0;
      safe_pin_oe <= nxt_safe_low;
    end
  end

endmodule

// ==== tb/ssc_pin_model.sv ====
// far-side model of the reset pin wire: pull-up plus shorts
`timescale 1ns/1ps
module ssc_pin_model (
  // drive from the block and fault controls
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic stuck_lo,
  input wire logic stuck_hi,
  // wire level back to the block
  output logic rst_pin_in
);
  // a short beats the driver; released wire floats up to the pull-up
  assign rst_pin_in = stuck_lo ? 1'b0 : stuck_hi ? 1'b1 : rst_pin_oe ? rst_pin_out : 1'b1;
endmodule

// ==== tb/ssc_properties.sv ====
// port assertions for the supply and debug control block
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_chk (
  // clock, reset and modes
  input wire logic clk, rst_n, init_enter, mode_normal, mode_low_power_vdd_on, fault_event,
  // settings and writes
  input wire logic [1:0] cfg_overcur_action,
  input wire logic cfg_uv_lower_sel, wr_can_reg, wr_can_reg_on, wr_mon, wr_debug_exit,
  // detectors and pins
  input wire logic aux_oc_in, uv_threshold_upper, uv_threshold_lower, debug_select_pin, vdd_overcur_in,
  // block outputs
  input wire logic can_reg_en, lin_trx_en, analog_monitor_en, aux_regulator_en, aux_fault_flag,
  input wire logic [2:0] analog_monitor_sel,
  input wire logic rst_pin_oe, uv_irq, oc_wake, debug_active, wdog_enable, safe_pin_oe, safe_pin_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // overcurrent rise held through the sync delay in low power
  sequence lp_oc;
    $rose(vdd_overcur_in) && mode_low_power_vdd_on ##1 mode_low_power_vdd_on [*2];
  endsequence
  // upper crossing while the lower threshold is chosen in normal mode
  sequence uv_warn;
    $rose(uv_threshold_upper) && cfg_uv_lower_sel && mode_normal ##1 (cfg_uv_lower_sel && mode_normal) [*2];
  endsequence
  can_on_a: assert property (wr_can_reg && wr_can_reg_on |=> can_reg_en) else $error("can off");
  trx_gate_a: assert property (!can_reg_en |-> !lin_trx_en && !analog_monitor_en) else $error("trx on");
  mon_keep_a: assert property (wr_mon && !can_reg_en |=> $stable(analog_monitor_sel)) else $error("sel");
  aux_trip_a: assert property ($rose(aux_oc_in) |-> ##3 !aux_regulator_en && aux_fault_flag) else $error("aux");
  uv_low_a: assert property (uv_threshold_lower [*3] |=> rst_pin_oe) else $error("uv low");
  uv_up_a: assert property ((uv_threshold_upper && !cfg_uv_lower_sel) [*3] |=> rst_pin_oe) else $error("uv up");
  uv_irq_a: assert property (uv_warn |=> uv_irq) else $error("uv irq");
  oc_wake_a: assert property (lp_oc ##0 cfg_overcur_action == `SSC_OC_ACT_WAKE |=> oc_wake) else $error("oc");
  dbg_entry_a: assert property (debug_select_pin [*3] ##0 init_enter |=> debug_active) else $error("dbg in");
  dbg_exit_a: assert property (wr_debug_exit |=> !debug_active) else $error("dbg out");
  wdog_off_a: assert property (wdog_enable == !debug_active) else $error("wdog");
  safe_low_a: assert property (fault_event |=> safe_pin_oe && !safe_pin_out) else $error("safe");
endmodule
bind ssc_supply_ctrl ssc_chk ssc_chk_i (.*);

// ==== tb/tb_ssc_supply_ctrl.sv ====
// self-checking bench for the supply and debug control block
`timescale 1ns/1ps
`include "ssc_map.svh"
module tb_ssc_supply_ctrl;
  // stimulus
  logic clk = 0, rst_n = 0, stuck_lo = 0, stuck_hi = 0, link_run = 0, pz_clr = 0;
  logic init_enter = 0, mode_normal = 0, mode_low_power = 0, mode_low_power_vdd_on = 0, cyclic_sense_en = 0;
  logic reset_request = 0, fault_event = 0, cfg_pnp_en = 0, cfg_uv_lower_sel = 0, cfg_aux_irq_en = 0;
  logic cfg_mon_load_en = 0, wr_can_reg = 0, wr_can_reg_on = 0, wr_aux = 0, wr_aux_on = 0, wr_aux_3v3 = 0;
  logic wr_aux_flag_clr = 0, wr_rst_fail_clr = 0, wr_io = 0, wr_mon = 0, wr_debug_exit = 0, wr_safe = 0;
  logic wr_safe_release = 0, vdd_overcur_in = 0, aux_uv_in = 0, aux_oc_in = 0, uv_threshold_upper = 0;
  logic uv_threshold_lower = 0, debug_select_pin = 1, cyclic_clk_in = 0;
  logic [1:0] cfg_overcur_action = 2'h3, wr_safe_mode = 2'h0, debug_res_code = 2'h2;
  logic [7:0] wr_io_mode = 8'h00;
  logic [2:0] wr_mon_sel = 3'h0;
  logic [3:0] io_pin_in = 4'hF;
  // outputs
  logic pnp_base_en, can_reg_en, lin_trx_en, aux_regulator_en, aux_3v3, aux_fault_flag, aux_irq, rst_pin_in;
  logic oc_wake, oc_timer_start, oc_wdog_refresh, rst_pin_out, rst_pin_oe, rst_fail_flag, uv_irq;
  logic io_prot_en, analog_monitor_en, analog_monitor_load, debug_active, wdog_enable, safe_pin_out, safe_pin_oe;
  logic [3:0] io_hs_on, io_ls_on, io_wake_in;
  logic [2:0] analog_monitor_sel;
  logic [1:0] safe_mode;
  logic [4:0] pz = 5'h00;
  // undervoltage cases: lower select, normal, upper, lower, expected reset
  logic [4:0] uvt [5] = '{5'h1C, 5'h1F, 5'h0D, 5'h15, 5'h03};
  int miscompares = 0, n_checks = 0, hi = 0;
  ssc_supply_ctrl ssc_supply_ctrl_i (.*);
  ssc_pin_model ssc_pin_model_i (.*);
  // clocks; the link clock idles low outside cyclic sensing
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #3;
    forever #40 cyclic_clk_in = link_run ? ~cyclic_clk_in : 1'b0;
  end
  // one-cycle pulses are caught here so no cycle is missed
  always @(posedge clk) pz <= pz_clr ? 5'h00 : (pz | {uv_irq, aux_irq, oc_wdog_refresh, oc_timer_start, oc_wake});
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pls(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
  endtask
  task automatic do_reset();
    rst_n = 0;
    cyc(2);
    rst_n = 1;
    // two edges of reset release plus two synchroniser edges plus one output edge
    cyc(6);
  endtask
  task end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // cut a hang short, far beyond the expected run
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
  initial begin
    do_reset();
    chk("can", 0, can_reg_en);
    chk("aux", 0, aux_regulator_en);
    chk("rstpin", 0, rst_pin_out);
    chk("io", 0, {io_hs_on, io_ls_on});
    chk("wake", 4'hF, io_wake_in);
    pls(init_enter);
    chk("dbg", 1, debug_active);
    chk("wdog", 0, wdog_enable);
    chk("can", 1, can_reg_en);
    chk("safe", 0, safe_mode);
    pls(wr_debug_exit);
    cyc(1);
    chk("dbg", 0, debug_active);
    chk("safe", 2, safe_mode);
    wr_safe_mode = 2'h3;
    pls(wr_safe);
    chk("safe", 3, safe_mode);
    // second reset mid-run, window then lost
    do_reset();
    pls(init_enter);
    debug_select_pin = 0;
    cyc(5);
    chk("dbg", 0, debug_active);
    mode_normal = 1;
    pls(wr_can_reg);
    chk("trx", 0, {lin_trx_en, analog_monitor_en});
    wr_mon_sel = 3'h3;
    pls(wr_mon);
    chk("sel", 0, analog_monitor_sel);
    wr_can_reg_on = 1;
    pls(wr_can_reg);
    cyc(8);
    chk("trx", 3, {lin_trx_en, analog_monitor_en});
    for (int s = 0; s < 8; s++) begin
      wr_mon_sel = s[2:0];
      pls(wr_mon);
      chk("sel", 8'((s == 7) ? 6 : s), analog_monitor_sel);
      cyc(1);
    end
    cfg_mon_load_en = 1;
    cfg_pnp_en = 1;
    cyc(2);
    chk("load", 1, analog_monitor_load);
    chk("pnp", 1, pnp_base_en);
    cfg_aux_irq_en = 1;
    wr_aux_on = 1;
    for (int k = 0; k < 2; k++) begin
      wr_aux_3v3 = k[0];
      pls(wr_aux);
      chk("aux", {k[0], 1'b1}, {aux_3v3, aux_regulator_en});
      if (k == 0) aux_uv_in = 1;
      else aux_oc_in = 1;
      pls(pz_clr);
      cyc(5);
      chk("auxf", 3'h6, {pz[3], aux_fault_flag, aux_regulator_en});
      {aux_uv_in, aux_oc_in} = 2'h0;
      cyc(4);
      pls(wr_aux_flag_clr);
      chk("auxf", 0, aux_fault_flag);
    end
    foreach (uvt[i]) begin
      {cfg_uv_lower_sel, mode_normal, uv_threshold_upper, uv_threshold_lower} = uvt[i][4:1];
      mode_low_power_vdd_on = !mode_normal;
      pls(pz_clr);
      cyc(5);
      chk("rst", uvt[i][0], rst_pin_oe);
      chk("uvirq", uvt[i][4] & uvt[i][3], pz[4]);
      {uv_threshold_upper, uv_threshold_lower} = 2'h0;
      cyc(6);
    end
    {mode_normal, mode_low_power_vdd_on} = 2'h2;
    for (int k = 0; k < 2; k++) begin
      {reset_request, stuck_hi, stuck_lo} = k ? 3'h6 : 3'h1;
      cyc(`SSC_RST_SETTLE_CYC + 10);
      chk("rstfail", 1, rst_fail_flag);
      {reset_request, stuck_hi, stuck_lo} = 3'h0;
      cyc(4);
      pls(wr_rst_fail_clr);
      chk("rstfail", 0, rst_fail_flag);
    end
    wr_io_mode = 8'h39;
    pls(wr_io);
    cyc(2);
    chk("io", 8'h12, {io_hs_on, io_ls_on});
    chk("wake", 4'h8, io_wake_in);
    chk("prot", 1, io_prot_en);
    {mode_normal, mode_low_power, mode_low_power_vdd_on} = 3'h3;
    for (int a = 0; a < 3; a++) begin
      cfg_overcur_action = a[1:0];
      vdd_overcur_in = 1;
      pls(pz_clr);
      cyc(5);
      chk("oc", 3'h1 << a, pz[2:0]);
      vdd_overcur_in = 0;
      cyc(4);
    end
    chk("io", 8'h12, {io_hs_on, io_ls_on});
    chk("prot", 0, io_prot_en);
    {cyclic_sense_en, link_run} = 2'h3;
    repeat (40) begin
      cyc(1);
      hi += io_hs_on[0];
    end
    chk("cyc", 1, hi > 5 && hi < 35);
    chk("wake", 4'hE, io_wake_in);
    chk("ls", 0, io_ls_on);
    {cyclic_sense_en, link_run} = 2'h0;
    pls(fault_event);
    cyc(3);
    chk("safepin", 2, {safe_pin_oe, safe_pin_out});
    pls(wr_safe_release);
    chk("safepin", 0, safe_pin_oe);
    end_sim();
  end
endmodule
